// ===== pkg/iefb_pkg.sv
// Constants shared by the interrupt enable and flag bank.
package iefb_pkg;

    // ------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W = 5;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned BE_W   = 4;
    localparam int unsigned REG_W  = 8;
    localparam int unsigned EXT_N  = 4;
    localparam int unsigned STS_W  = 6;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFF_EN1 = 5'h00;
    localparam logic [ADDR_W-1:0] OFF_EN2 = 5'h04;
    localparam logic [ADDR_W-1:0] OFF_FLG = 5'h08;
    localparam logic [ADDR_W-1:0] OFF_CTL = 5'h0C;
    localparam logic [ADDR_W-1:0] OFF_STS = 5'h10;
    localparam logic [ADDR_W-1:0] OFF_MSK = 5'h14;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int unsigned BIT_DT   = 7;
    localparam int unsigned BIT_RTC  = 6;
    localparam int unsigned BIT_WKP  = 5;
    localparam int unsigned BIT_TMR  = 5;
    localparam int unsigned CTL_FN   = 4;
    localparam int unsigned STS_DT   = 5;
    localparam int unsigned STS_RTC  = 4;
    localparam int unsigned BE_LANE0 = 0;

    // ------------------------------------------------------------
    // Writable masks, read-as-one masks and reset values
    // ------------------------------------------------------------
    localparam logic [REG_W-1:0] EN1_WMASK = 8'hEF;
    localparam logic [REG_W-1:0] EN1_RONE  = 8'h10;
    localparam logic [REG_W-1:0] EN2_WMASK = 8'h20;
    localparam logic [REG_W-1:0] EN2_RONE  = 8'h1F;
    localparam logic [REG_W-1:0] FLG_MASK  = 8'hCF;
    localparam logic [REG_W-1:0] FLG_RONE  = 8'h30;
    localparam logic [REG_W-1:0] REG_RST   = 8'h00;
    localparam logic [STS_W-1:0] STS_RST   = 6'h00;
    localparam logic [DATA_W-1:0] RD_NONE  = 32'h00000000;

endpackage

// ===== verilog/iefb_edge_detect.sv
// Pin synchroniser and selectable edge detector for the external request pins.
`timescale 1ns/1ns
`default_nettype none

module iefb_edge_detect #(
    parameter int unsigned WIDTH = 4
) (
    input  wire logic             sys_clk,
    input  wire logic             resetn,
    input  wire logic             clk_en,
    input  wire logic [WIDTH-1:0] pin,
    input  wire logic [WIDTH-1:0] rise_select,
    output logic      [WIDTH-1:0] edge_hit
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] prev_q;
    logic [WIDTH-1:0] rise_w;
    logic [WIDTH-1:0] fall_w;

    // ------------------------------------------------------------
    // Two-stage synchroniser and history
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            meta_q <= '1;
            sync_q <= '1;
            prev_q <= '1;
        end else if (clk_en) begin
            meta_q <= pin;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    // ------------------------------------------------------------
    // Edge choice
    // ------------------------------------------------------------
    assign rise_w   = sync_q & ~prev_q;
    assign fall_w   = ~sync_q & prev_q;
    assign edge_hit = (rise_select & rise_w) | (~rise_select & fall_w);

endmodule

`default_nettype wire

// ===== verilog/iefb_interrupt_bank.sv
// Interrupt enable and request flag register bank with an Avalon-MM slave.
// Function
// - Direct-transition requests pass only while enable one bit 7 is set; resets to 0.
// - Real-time-clock requests pass only while enable one bit 6 is set; resets to 0.
// - Enable one bit 5 is one shared enable for all six wakeup pins.
// - Enable one bit 4 always reads 1 and stores nothing.
// - Enable one bits 3 to 0 each enable their own external request pin.
// - A clear colliding with an arriving request still leaves that request taken.
// - Enable two bits 7 and 6 always read 0.
// - Enable two bit 5 lets timer overflow requests through; resets to 0.
// - Enable two bits 4 to 0 and flag bits 5 and 4 read 1.
// - Flag bit 7 sets on a sleep direct transition while direct_transition_on is 1.
// - Flags reset to 0 and clear only when software writes 0.
// - Flag bit 6 sets when the real-time-clock counter overflows.
// - Flags 3 to 0 set on the selected edge of an interrupt-configured pin.
// - Edge select 0 picks falling edges, 1 picks rising edges.
`timescale 1ns/1ns
`default_nettype none

module iefb_interrupt_bank #(
    parameter int unsigned WKP_N = 6
) (
    input  wire logic                                sys_clk,
    input  wire logic                                resetn,
    input  wire logic                                clk_en,
    input  wire logic [iefb_pkg::ADDR_W-1:0]         avs_address,
    input  wire logic                                avs_read,
    input  wire logic                                avs_write,
    input  wire logic [iefb_pkg::DATA_W-1:0]         avs_writedata,
    input  wire logic [iefb_pkg::BE_W-1:0]           avs_byteenable,
    output logic      [iefb_pkg::DATA_W-1:0]         avs_readdata,
    output logic                                     avs_waitrequest,
    input  wire logic [iefb_pkg::EXT_N-1:0]          ext_request_pin,
    input  wire logic                                sleep_direct_transition,
    input  wire logic                                direct_transition_on,
    input  wire logic                                rtc_overflow,
    input  wire logic [WKP_N-1:0]                    wakeup_flags,
    input  wire logic                                timer_overflow_flag,
    output logic                                     dt_request,
    output logic                                     rtc_request,
    output logic                                     wakeup_request,
    output logic      [iefb_pkg::EXT_N-1:0]          ext_request,
    output logic                                     timer_request,
    output logic                                     irq
);

    function automatic logic [iefb_pkg::DATA_W-1:0] widen(input logic [iefb_pkg::REG_W-1:0] v);
        widen = {{(iefb_pkg::DATA_W - iefb_pkg::REG_W){1'b0}}, v};
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [iefb_pkg::REG_W-1:0]  en1_q;
    logic [iefb_pkg::REG_W-1:0]  en2_q;
    logic [iefb_pkg::REG_W-1:0]  flags_q;
    logic [iefb_pkg::REG_W-1:0]  flags_d;
    logic [iefb_pkg::REG_W-1:0]  ctl_q;
    logic [iefb_pkg::STS_W-1:0]  sts_q;
    logic [iefb_pkg::STS_W-1:0]  sts_d;
    logic [iefb_pkg::STS_W-1:0]  msk_q;
    logic [iefb_pkg::DATA_W-1:0] rdata_q;
    logic                        wait_q;
    logic                        dt_req_q;
    logic                        rtc_req_q;
    logic                        wkp_req_q;
    logic [iefb_pkg::EXT_N-1:0]  ext_req_q;
    logic                        tmr_req_q;
    logic                        irq_q;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire logic                       bus_req;
    wire logic                       wr_fire;
    wire logic [iefb_pkg::REG_W-1:0] wd8;
    wire logic                       sel_en1;
    wire logic                       sel_en2;
    wire logic                       sel_flg;
    wire logic                       sel_ctl;
    wire logic                       sel_sts;
    wire logic                       sel_msk;
    wire logic [iefb_pkg::DATA_W-1:0] rd_mux;

    assign bus_req = avs_read | avs_write;
    assign wr_fire = avs_write & ~wait_q & avs_byteenable[iefb_pkg::BE_LANE0];
    assign wd8     = avs_writedata[iefb_pkg::REG_W-1:0];
    assign sel_en1 = avs_address == iefb_pkg::OFF_EN1;
    assign sel_en2 = avs_address == iefb_pkg::OFF_EN2;
    assign sel_flg = avs_address == iefb_pkg::OFF_FLG;
    assign sel_ctl = avs_address == iefb_pkg::OFF_CTL;
    assign sel_sts = avs_address == iefb_pkg::OFF_STS;
    assign sel_msk = avs_address == iefb_pkg::OFF_MSK;

    assign rd_mux = sel_en1 ? widen(en1_q | iefb_pkg::EN1_RONE) :
                    sel_en2 ? widen((en2_q & iefb_pkg::EN2_WMASK) | iefb_pkg::EN2_RONE) :
                    sel_flg ? widen(flags_q | iefb_pkg::FLG_RONE) :
                    sel_ctl ? widen(ctl_q) :
                    sel_sts ? widen({{(iefb_pkg::REG_W - iefb_pkg::STS_W){1'b0}}, sts_q}) :
                    sel_msk ? widen({{(iefb_pkg::REG_W - iefb_pkg::STS_W){1'b0}}, msk_q}) :
                    iefb_pkg::RD_NONE;

    // ------------------------------------------------------------
    // Request sources
    // ------------------------------------------------------------
    wire logic [iefb_pkg::EXT_N-1:0] edge_hit;
    wire logic [iefb_pkg::EXT_N-1:0] ext_set;
    wire logic                       dt_set;
    wire logic [iefb_pkg::REG_W-1:0] flag_set;
    wire logic [iefb_pkg::REG_W-1:0] flag_clr;
    wire logic [iefb_pkg::STS_W-1:0] sts_set;
    wire logic [iefb_pkg::STS_W-1:0] sts_clr;

    iefb_edge_detect #(
        .WIDTH       (iefb_pkg::EXT_N)
    ) u_edge (
        .sys_clk     (sys_clk),
        .resetn      (resetn),
        .clk_en      (clk_en),
        .pin         (ext_request_pin),
        .rise_select (ctl_q[iefb_pkg::EXT_N-1:0]),
        .edge_hit    (edge_hit)
    );

    assign ext_set  = edge_hit & ctl_q[iefb_pkg::CTL_FN +: iefb_pkg::EXT_N];
    assign dt_set   = sleep_direct_transition & direct_transition_on;
    assign flag_set = {dt_set, rtc_overflow, 2'b00, ext_set};

    // Software may only clear; a one written leaves the flag alone.
    assign flag_clr = (wr_fire && sel_flg) ? (~wd8 & iefb_pkg::FLG_MASK)
                                           : iefb_pkg::REG_RST;
    // Set wins over clear so a colliding request is never lost.
    assign flags_d  = (flags_q & ~flag_clr) | flag_set;

    assign sts_set  = {dt_set, rtc_overflow, ext_set};
    assign sts_clr  = (wr_fire && sel_sts) ? wd8[iefb_pkg::STS_W-1:0] : iefb_pkg::STS_RST;
    assign sts_d    = (sts_q & ~sts_clr) | sts_set;

    // ------------------------------------------------------------
    // Avalon-MM handshake
    // ------------------------------------------------------------
    // Every access waits exactly one cycle, which leaves time to register read data.
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            wait_q  <= 1'b1;
            rdata_q <= iefb_pkg::RD_NONE;
        end else if (clk_en) begin
            wait_q <= ~(bus_req & wait_q);
            if (avs_read && wait_q) begin
                rdata_q <= rd_mux;
            end
        end
    end

    // ------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            en1_q <= iefb_pkg::REG_RST;
            en2_q <= iefb_pkg::REG_RST;
            ctl_q <= iefb_pkg::REG_RST;
            msk_q <= iefb_pkg::STS_RST;
        end else if (clk_en && wr_fire) begin
            if (sel_en1) begin
                en1_q <= wd8 & iefb_pkg::EN1_WMASK;
            end
            if (sel_en2) begin
                en2_q <= wd8 & iefb_pkg::EN2_WMASK;
            end
            if (sel_ctl) begin
                ctl_q <= wd8;
            end
            if (sel_msk) begin
                msk_q <= wd8[iefb_pkg::STS_W-1:0];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            flags_q <= iefb_pkg::REG_RST;
            sts_q   <= iefb_pkg::STS_RST;
        end else if (clk_en) begin
            flags_q <= flags_d & iefb_pkg::FLG_MASK;
            sts_q   <= sts_d;
        end
    end

    // ------------------------------------------------------------
    // Requests to the CPU
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            dt_req_q  <= 1'b0;
            rtc_req_q <= 1'b0;
            wkp_req_q <= 1'b0;
            ext_req_q <= '0;
            tmr_req_q <= 1'b0;
            irq_q     <= 1'b0;
        end else if (clk_en) begin
            dt_req_q  <= flags_q[iefb_pkg::BIT_DT] & en1_q[iefb_pkg::BIT_DT];
            rtc_req_q <= flags_q[iefb_pkg::BIT_RTC] & en1_q[iefb_pkg::BIT_RTC];
            wkp_req_q <= (|wakeup_flags) & en1_q[iefb_pkg::BIT_WKP];
            ext_req_q <= flags_q[iefb_pkg::EXT_N-1:0] & en1_q[iefb_pkg::EXT_N-1:0];
            tmr_req_q <= timer_overflow_flag & en2_q[iefb_pkg::BIT_TMR];
            irq_q     <= |(sts_q & msk_q);
        end
    end

    assign avs_readdata    = rdata_q;
    assign avs_waitrequest = wait_q;
    assign dt_request      = dt_req_q;
    assign rtc_request     = rtc_req_q;
    assign wakeup_request  = wkp_req_q;
    assign ext_request     = ext_req_q;
    assign timer_request   = tmr_req_q;
    assign irq             = irq_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);

    sequence req_waiting;
        clk_en && bus_req && avs_waitrequest;
    endsequence

    sequence read_en1;
        clk_en && avs_read && avs_waitrequest && sel_en1;
    endsequence

    sequence read_en2;
        clk_en && avs_read && avs_waitrequest && sel_en2;
    endsequence

    sequence read_flg;
        clk_en && avs_read && avs_waitrequest && sel_flg;
    endsequence

    bus_ack_a: assert property (req_waiting |=> !avs_waitrequest)
        else $error("Request not answered after one wait cycle.");
    bus_release_a: assert property (req_waiting ##1 clk_en |=> avs_waitrequest)
        else $error("Wait request did not return high after the answer.");

    en1_reserved_a: assert property (read_en1 |=> avs_readdata[4] && !avs_waitrequest)
        else $error("Reserved enable one bit did not read as one.");
    en2_reserved_a: assert property (read_en2 |=>
        avs_readdata[7:6] == 2'b00 && avs_readdata[4:0] == 5'h1F)
        else $error("Reserved enable two bits read wrong.");
    flg_reserved_a: assert property (read_flg |=> avs_readdata[5:4] == 2'b11)
        else $error("Reserved flag bits did not read as one.");

    flag_clear_a: assert property (clk_en && wr_fire && sel_flg
        && !wd8[iefb_pkg::BIT_RTC] && !rtc_overflow |=> !flags_q[iefb_pkg::BIT_RTC])
        else $error("Writing zero did not clear the flag.");
    flag_no_set_a: assert property (clk_en && !flags_q[iefb_pkg::BIT_RTC]
        && !rtc_overflow |=> !flags_q[iefb_pkg::BIT_RTC])
        else $error("Flag set without an event.");
    set_wins_a: assert property (clk_en && rtc_overflow
        |=> flags_q[iefb_pkg::BIT_RTC])
        else $error("Overflow event lost.");
    dt_flag_a: assert property (clk_en && !flags_q[iefb_pkg::BIT_DT]
        |=> flags_q[iefb_pkg::BIT_DT] == $past(dt_set))
        else $error("Direct transition flag wrong.");
    rtc_req_a: assert property (clk_en |=>
        rtc_request == $past(flags_q[iefb_pkg::BIT_RTC] & en1_q[iefb_pkg::BIT_RTC]))
        else $error("Clock request does not follow flag and enable.");
    ext_req_a: assert property (clk_en && en1_q[0] && flags_q[0]
        |=> ext_request[0])
        else $error("External request zero not presented.");
    timer_req_a: assert property (clk_en && !en2_q[iefb_pkg::BIT_TMR]
        |=> !timer_request)
        else $error("Timer request passed while disabled.");

endmodule

`default_nettype wire

// ===== bench/iefb_event_model.sv
// Event source model that turns bench commands into one-cycle event pulses.
`timescale 1ns/1ns
`default_nettype none

module iefb_event_model (
    input  wire logic sys_clk,
    input  wire logic resetn,
    input  wire logic fire_rtc,
    input  wire logic fire_dt,
    output logic      rtc_overflow,
    output logic      sleep_direct_transition
);
    logic rtc_prev_q;
    logic dt_prev_q;

    // ------------------------------------------------------------
    // Pulse shaping
    // ------------------------------------------------------------
    // A held command yields one pulse only, so a slow bench never repeats an event.
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            rtc_prev_q              <= 1'b0;
            dt_prev_q               <= 1'b0;
            rtc_overflow            <= 1'b0;
            sleep_direct_transition <= 1'b0;
        end else begin
            rtc_prev_q              <= fire_rtc;
            dt_prev_q               <= fire_dt;
            rtc_overflow            <= fire_rtc & ~rtc_prev_q;
            sleep_direct_transition <= fire_dt & ~dt_prev_q;
        end
    end
endmodule

`default_nettype wire

// ===== bench/test_interrupt_enable_flag_bank.sv
// Self-checking testbench for the interrupt enable and flag bank.
`timescale 1ns/1ns
`default_nettype none

module test_interrupt_enable_flag_bank;
    localparam logic [4:0] A_E1 = iefb_pkg::OFF_EN1;
    localparam logic [4:0] A_E2 = iefb_pkg::OFF_EN2;
    localparam logic [4:0] A_FL = iefb_pkg::OFF_FLG;
    localparam logic [4:0] A_CT = iefb_pkg::OFF_CTL;
    localparam logic [4:0] A_ST = iefb_pkg::OFF_STS;
    localparam logic [4:0] A_MS = iefb_pkg::OFF_MSK;
    localparam logic [4:0] A_NO = 5'h18;

    logic        sys_clk, resetn, avs_read, avs_write, avs_waitrequest;
    logic [4:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0]  avs_byteenable, pins, ext_request;
    logic        fire_rtc, fire_dt, rtc_overflow, sleep_dt, dt_on, tmr, ce;
    logic [5:0]  wk;
    logic        dt_request, rtc_request, wakeup_request, timer_request, irq;
    int          n_fail, n_tests;

    iefb_event_model model_u (.sys_clk(sys_clk), .resetn(resetn), .fire_rtc(fire_rtc),
        .fire_dt(fire_dt), .rtc_overflow(rtc_overflow), .sleep_direct_transition(sleep_dt));

    iefb_interrupt_bank dut_u (.sys_clk(sys_clk), .resetn(resetn), .clk_en(ce),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .ext_request_pin(pins), .sleep_direct_transition(sleep_dt),
        .direct_transition_on(dt_on), .rtc_overflow(rtc_overflow), .wakeup_flags(wk),
        .timer_overflow_flag(tmr), .dt_request(dt_request), .rtc_request(rtc_request),
        .wakeup_request(wakeup_request), .ext_request(ext_request),
        .timer_request(timer_request), .irq(irq));

    // ------------------------------------------------------------
    // Clock, checks and bus tasks
    // ------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // The request is held until waitrequest is seen low; one idle edge follows.
    task automatic wr(input logic [4:0] a, input logic [7:0] d, input logic be0 = 1'b1);
        avs_address    <= a;
        avs_writedata  <= {24'h000000, d};
        avs_byteenable <= {3'h7, be0};
        avs_write      <= 1'b1;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic rd(input logic [4:0] a, input logic [7:0] exp);
        logic [31:0] got;
        avs_address <= a;
        avs_read    <= 1'b1;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        got = avs_readdata;
        avs_read <= 1'b0;
        chk(got[7:0], exp);
        chk(got[31:24] | got[23:16] | got[15:8], 8'h00);
        @(posedge sys_clk);
    endtask

    task automatic wait_clk(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    task automatic pulse(input logic rtc);
        if (rtc) fire_rtc <= 1'b1;
        else fire_dt <= 1'b1;
        wait_clk(1);
        fire_rtc <= 1'b0;
        fire_dt  <= 1'b0;
        wait_clk(4);
    endtask

    task automatic close_out;
        $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        wait_clk(5000);
        n_fail++;
        $display("[ERR] %0t watchdog expired", $time);
        close_out();
    end

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        n_fail = 0;
        n_tests = 0;
        resetn = 1'b0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 5'h00;
        avs_writedata = 32'h00000000;
        avs_byteenable = 4'hF;
        pins = 4'hF;
        fire_rtc = 1'b0;
        fire_dt = 1'b0;
        ce = 1'b1;
        dt_on = 1'b0;
        tmr = 1'b0;
        wk = 6'h00;
        wait_clk(3);
        resetn <= 1'b1;
        rd(A_E1, 8'h10);
        rd(A_E2, 8'h1F);
        rd(A_FL, 8'h30);
        rd(A_NO, 8'h00);
        wr(A_E1, 8'hFF);
        rd(A_E1, 8'hFF);
        wr(A_E1, 8'h00);
        rd(A_E1, 8'h10);
        wr(A_E2, 8'hFF);
        rd(A_E2, 8'h3F);
        wr(A_E2, 8'h00);
        wr(A_E2, 8'hFF, 1'b0);
        rd(A_E2, 8'h1F);
        wr(A_NO, 8'hFF);
        rd(A_NO, 8'h00);
        pins <= 4'h0;
        wait_clk(6);
        pins <= 4'hF;
        wait_clk(6);
        rd(A_FL, 8'h30);
        pulse(1'b1);
        chk({7'h00, rtc_request}, 8'h00);
        rd(A_FL, 8'h70);
        wr(A_E1, 8'h40);
        wait_clk(3);
        chk({7'h00, rtc_request}, 8'h01);
        wr(A_FL, 8'hFF);
        rd(A_FL, 8'h70);
        wr(A_FL, 8'hBF);
        rd(A_FL, 8'h30);
        chk({7'h00, rtc_request}, 8'h00);
        fire_rtc <= 1'b1;
        wr(A_FL, 8'hBF);
        fire_rtc <= 1'b0;
        rd(A_FL, 8'h70);
        wr(A_FL, 8'hBF);
        pulse(1'b0);
        rd(A_FL, 8'h30);
        // A frozen bank must not latch an overflow that arrives while the enable is low.
        ce <= 1'b0;
        pulse(1'b1);
        ce <= 1'b1;
        rd(A_FL, 8'h30);
        dt_on <= 1'b1;
        pulse(1'b0);
        chk({7'h00, dt_request}, 8'h00);
        wr(A_E1, 8'h80);
        wait_clk(3);
        chk({7'h00, dt_request}, 8'h01);
        rd(A_FL, 8'hB0);
        wr(A_FL, 8'h7F);
        wr(A_CT, 8'hF5);
        rd(A_CT, 8'hF5);
        wr(A_E1, 8'h0F);
        pins <= 4'h0;
        wait_clk(6);
        rd(A_FL, 8'h3A);
        pins <= 4'hF;
        wait_clk(6);
        rd(A_FL, 8'h3F);
        chk({4'h0, ext_request}, 8'h0F);
        wr(A_E1, 8'h05);
        wait_clk(3);
        chk({4'h0, ext_request}, 8'h05);
        rd(A_ST, 8'h3F);
        chk({7'h00, irq}, 8'h00);
        wr(A_MS, 8'h3F);
        rd(A_MS, 8'h3F);
        wait_clk(3);
        chk({7'h00, irq}, 8'h01);
        wr(A_ST, 8'h3F);
        rd(A_ST, 8'h00);
        wait_clk(3);
        chk({7'h00, irq}, 8'h00);
        wk <= 6'h04;
        wait_clk(3);
        chk({7'h00, wakeup_request}, 8'h00);
        wr(A_E1, 8'h20);
        wait_clk(3);
        chk({7'h00, wakeup_request}, 8'h01);
        tmr <= 1'b1;
        wait_clk(3);
        chk({7'h00, timer_request}, 8'h00);
        wr(A_E2, 8'h20);
        wait_clk(3);
        chk({7'h00, timer_request}, 8'h01);
        // A second reset in mid-run must bring every enable and flag back to zero.
        resetn <= 1'b0;
        wait_clk(3);
        resetn <= 1'b1;
        rd(A_FL, 8'h30);
        rd(A_E1, 8'h10);
        chk({7'h00, wakeup_request}, 8'h00);
        chk({7'h00, timer_request}, 8'h00);
        close_out();
    end
endmodule

`default_nettype wire
